// ---- src/sdol_pkg.sv ----
// package: constants for the start-up delay and output latch block
package sdol_pkg;
  // wishbone register byte offsets
  localparam logic [3:0] SDOL_CFG_OFS    = 4'h0;
  localparam logic [3:0] SDOL_STAT_OFS   = 4'h4;
  localparam logic [3:0] SDOL_IRQ_OFS    = 4'h8;
  localparam logic [3:0] SDOL_MASK_OFS   = 4'hc;
  // cfg register field positions
  localparam int SDOL_MODE_LSB  = 0;
  localparam int SDOL_DASG_LSB  = 4;
  localparam int SDOL_LASG_LSB  = 8;
  localparam int SDOL_STILL_LSB = 16;
  // start-up mode codes
  localparam logic [3:0] SDOL_MODE_OFF    = 4'h0;
  localparam logic [3:0] SDOL_MODE_T_MAX  = 4'h8;
  localparam logic [3:0] SDOL_MODE_AUTO   = 4'h9;
  localparam logic [3:0] SDOL_MODE_REMOTE = 4'ha;
  // reset values
  localparam logic [31:0] SDOL_CFG_RST  = 32'h0001_0000;
  localparam logic [2:0]  SDOL_MASK_RST = 3'h0;
  // timing
  localparam int SDOL_CLK_HZ       = 20_000_000;
  localparam int SDOL_TICK_S       = 1;
  localparam int SDOL_TICK_CYCLES  = SDOL_CLK_HZ * SDOL_TICK_S;
  // interrupt bit positions
  localparam int SDOL_IRQ_DLY_END  = 0;
  localparam int SDOL_IRQ_STILL    = 1;
  localparam int SDOL_IRQ_RELEASE  = 2;
endpackage : sdol_pkg

// ---- src/sdol_sec_if.sv ----
// interface: one-second tick carrier between timebase and core
`timescale 1ns/1ns
`default_nettype none
interface sdol_sec_if;
  logic tick;
  modport src (output tick);
  modport dst (input  tick);
endinterface : sdol_sec_if
`default_nettype wire

// ---- src/sdol_timebase.sv ----
// one-second tick generator from the internal clock
`timescale 1ns/1ns
`default_nettype none
module sdol_timebase
  import sdol_pkg::*;
#(
  parameter int TICK_CYCLES = SDOL_TICK_CYCLES
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // tick out
  sdol_sec_if.src   sec
);
  logic [31:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 32'h0;
    end else if (cnt_q == 32'(TICK_CYCLES - 1)) begin
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  assign sec.tick = (cnt_q == 32'(TICK_CYCLES - 1));
endmodule : sdol_timebase
`default_nettype wire

// ---- src/sdol_top.sv ----
// start-up delay and output latch conditioning for three switching outputs
//
// Register access over Wishbone and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module sdol_top
  import sdol_pkg::*;
#(
  parameter int TICK_CYCLES = SDOL_TICK_CYCLES,
  parameter int NOUT        = 3
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [3:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // monitor status inputs
  input  wire logic        freq_zero_i,
  input  wire logic        above_set_i,
  input  wire logic        remote_dly_i,
  input  wire logic        release_i,
  input  wire logic [2:0]  raw_out_i,
  // conditioned outputs
  output logic      [2:0]  out_o,
  output logic             delay_active_o,
  output logic             standstill_o,
  output logic             irq_o
);
  sdol_sec_if sec ();

  sdol_timebase #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tb (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .sec   (sec)
  );

  typedef enum logic [1:0] {SDOL_IDLE, SDOL_TIMED, SDOL_AUTO, SDOL_REMOTE} sdol_state_t;

  logic [31:0] cfg_q;
  logic [2:0]  irq_q;
  logic [2:0]  mask_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic [3:0]  mode;
  logic [2:0]  dasg;
  logic [3:0]  lasg;
  logic [15:0] still_s;
  logic        wr_cfg;
  logic        wr_irq;
  logic        wr_mask;

  assign mode    = cfg_q[SDOL_MODE_LSB +: 4];
  assign dasg    = cfg_q[SDOL_DASG_LSB +: 3];
  assign lasg    = cfg_q[SDOL_LASG_LSB +: 4];
  assign still_s = cfg_q[SDOL_STILL_LSB +: 16];

  // bus: one registered answer per request, the cycle after it; ack drops the cycle after
  wire req = cyc_i & stb_i & ~ack_q;
  assign wr_cfg  = req & we_i & (adr_i == SDOL_CFG_OFS);
  assign wr_irq  = req & we_i & (adr_i == SDOL_IRQ_OFS);
  assign wr_mask = req & we_i & (adr_i == SDOL_MASK_OFS);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_cfg
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cfg_q[b*8 +: 8] <= SDOL_CFG_RST[b*8 +: 8];
        end else if (wr_cfg && sel_i[b]) begin
          cfg_q[b*8 +: 8] <= dat_i[b*8 +: 8];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= SDOL_MASK_RST;
    end else if (wr_mask && sel_i[0]) begin
      mask_q <= dat_i[2:0];
    end
  end

  // standstill timer: one spare tick, since the free-running tick phase
  // could otherwise declare standstill up to a second before the interval
  logic [16:0] zero_cnt_q;
  logic        still_q;
  logic        still_due;

  assign still_due = (still_s == 16'h0) || (zero_cnt_q > {1'b0, still_s});

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      zero_cnt_q <= 17'h0;
    end else if (!freq_zero_i) begin
      zero_cnt_q <= 17'h0;
    end else if (!still_due && sec.tick) begin
      zero_cnt_q <= zero_cnt_q + 17'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      still_q <= 1'b0;
    end else if (!freq_zero_i) begin
      still_q <= 1'b0;
    end else if (still_due) begin
      still_q <= 1'b1;
    end
  end

  // standstill exit restarts the delay; reset release does too
  logic still_d1_q;
  logic boot_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      still_d1_q <= 1'b0;
      boot_q     <= 1'b1;
    end else begin
      still_d1_q <= still_q;
      boot_q     <= 1'b0;
    end
  end
  wire restart = boot_q | (still_d1_q & ~still_q);

  // start-up delay sequencer
  sdol_state_t st_q;
  logic [7:0]  dly_cnt_q;
  logic [7:0]  dly_len;

  always_comb begin
    dly_len = 8'h0;
    if (mode != SDOL_MODE_OFF && mode <= SDOL_MODE_T_MAX) begin
      dly_len = 8'(8'h1 << (mode - 4'h1));
    end
  end

  // seconds counted in the timed state since the last restart
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dly_cnt_q <= 8'h0;
    end else if (restart) begin
      dly_cnt_q <= 8'h0;
    end else if (st_q == SDOL_TIMED && sec.tick) begin
      dly_cnt_q <= dly_cnt_q + 8'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= SDOL_IDLE;
    end else if (restart) begin
      if (mode == SDOL_MODE_OFF) begin
        st_q <= SDOL_IDLE;
      end else if (mode <= SDOL_MODE_T_MAX) begin
        st_q <= SDOL_TIMED;
      end else if (mode == SDOL_MODE_AUTO) begin
        st_q <= SDOL_AUTO;
      end else if (mode == SDOL_MODE_REMOTE) begin
        st_q <= SDOL_REMOTE;
      end else begin
        st_q <= SDOL_IDLE;
      end
    end else begin
      case (st_q)
        SDOL_TIMED: begin
          if (sec.tick && (dly_cnt_q + 8'h1 >= dly_len)) begin
            st_q <= SDOL_IDLE;
          end
        end
        SDOL_AUTO: begin
          if (above_set_i) begin
            st_q <= SDOL_IDLE;
          end
        end
        SDOL_REMOTE: begin
          st_q <= SDOL_REMOTE;
        end
        default: begin
          st_q <= SDOL_IDLE;
        end
      endcase
    end
  end

  logic dly_on;
  always_comb begin
    case (st_q)
      SDOL_TIMED:  dly_on = 1'b1;
      SDOL_AUTO:   dly_on = 1'b1;
      SDOL_REMOTE: dly_on = remote_dly_i;
      default:     dly_on = 1'b0;
    endcase
  end

  // release pulse from the key or control input
  logic rel_d1_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rel_d1_q <= 1'b0;
    end else begin
      rel_d1_q <= release_i;
    end
  end
  wire rel_pulse = release_i & ~rel_d1_q;

  // per-output gating and catch
  logic [2:0] gated;
  logic [2:0] catch_q;
  logic [2:0] out_q;
  genvar i;
  generate
    for (i = 0; i < NOUT; i++) begin : g_out
      // zero assignment leaves every output free of the delay; a set bit masks that output
      assign gated[i] = raw_out_i[i] & ~(dly_on & dasg[i]);
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          catch_q[i] <= 1'b0;
        end else if (!lasg[i]) begin
          catch_q[i] <= 1'b0;
        end else if (gated[i]) begin
          catch_q[i] <= 1'b1;
        end else if (rel_pulse) begin
          catch_q[i] <= 1'b0;
        end else if (lasg[3] && still_q) begin
          catch_q[i] <= 1'b0;
        end
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          out_q[i] <= 1'b0;
        end else begin
          out_q[i] <= gated[i] | catch_q[i];
        end
      end
    end
  endgenerate

  // sticky events: set wins over write-one clear
  logic dly_on_d1_q;
  logic [2:0] ev;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dly_on_d1_q <= 1'b0;
    end else begin
      dly_on_d1_q <= dly_on;
    end
  end
  assign ev[SDOL_IRQ_DLY_END] = dly_on_d1_q & ~dly_on;
  assign ev[SDOL_IRQ_STILL]   = still_q & ~still_d1_q;
  assign ev[SDOL_IRQ_RELEASE] = rel_pulse;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= 3'h0;
    end else begin
      irq_q <= (irq_q & ~((wr_irq && sel_i[0]) ? dat_i[2:0] : 3'h0)) | ev;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0;
    end else if (req && !we_i) begin
      case (adr_i)
        SDOL_CFG_OFS:  rdat_q <= cfg_q;
        SDOL_STAT_OFS: rdat_q <= {29'h0, dly_on, still_q, boot_q};
        SDOL_IRQ_OFS:  rdat_q <= {29'h0, irq_q};
        SDOL_MASK_OFS: rdat_q <= {29'h0, mask_q};
        default:       rdat_q <= 32'h0;
      endcase
    end
  end

  assign dat_o          = rdat_q;
  assign ack_o          = ack_q;
  assign out_o          = out_q;
  assign delay_active_o = dly_on;
  assign standstill_o   = still_q;
  assign irq_o          = |(irq_q & mask_q);
endmodule : sdol_top
`default_nettype wire

// ---- sim/sdol_top_properties.sv ----
// checker: port-level properties of the start-up delay block
`timescale 1ns/1ns
`default_nettype none
module sdol_top_properties (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       ack_o,
  input wire logic       freq_zero_i,
  input wire logic [2:0] raw_out_i,
  input wire logic [2:0] out_o,
  input wire logic       delay_active_o,
  input wire logic       standstill_o,
  input wire logic       irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_shot: assert property (ack_o |=> !ack_o) else $error("ack too long");
  a_ack_answers: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
  a_ack_unasked: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("stray ack");
  // reset must be seen, so this one is not disabled by it
  a_reset_quiet: assert property (disable iff (1'h0) rst_i |=>
    out_o == 3'h0 && !irq_o && !standstill_o && !delay_active_o) else $error("reset not quiet");
  a_out_follow:
    assert property (!delay_active_o |=> (out_o & $past(raw_out_i)) == $past(raw_out_i))
    else $error("output lost while undelayed");
  a_out_cause:
    assert property ((out_o & ~$past(out_o) & ~$past(raw_out_i)) == 3'h0)
    else $error("output set without activity");
  a_still_cause:
    assert property ($rose(standstill_o) |-> $past(freq_zero_i)) else $error("early standstill");
  a_still_hold:
    assert property (standstill_o && freq_zero_i |=> standstill_o) else $error("standstill lost");
endmodule // sdol_top_properties
bind sdol_top sdol_top_properties sdol_top_properties_i (.clk_i, .rst_i, .cyc_i, .stb_i,
  .ack_o, .freq_zero_i, .raw_out_i, .out_o, .delay_active_o, .standstill_o, .irq_o);
`default_nettype wire

// ---- sim/sdol_partner.sv ----
// partner: machine control pressing the release key
`timescale 1ns/1ns
`default_nettype none
module sdol_partner (
  input  wire logic clk_i,
  input  wire logic press_i,
  output logic      release_o
);
  // key held two cycles, so the block must make its own single pulse
  logic hold_q;
  always_ff @(posedge clk_i) begin
    hold_q    <= press_i;
    release_o <= press_i | hold_q;
  end
endmodule // sdol_partner
`default_nettype wire

// ---- sim/sdol_top_test.sv ----
// testbench: start-up delay, catch and standstill scenarios
`timescale 1ns/1ns
`default_nettype none
module sdol_top_test import sdol_pkg::*;;
  localparam int T = 10;
  logic        clk_i = 1'h0, rst_i = 1'h1, cyc_i, stb_i, we_i, ack_o, look = 1'h0;
  logic        freq_zero_i, above_set_i, remote_dly_i, release_i, press;
  logic        delay_active_o, standstill_o, irq_o;
  logic [3:0]  adr_i, sel_i = 4'hf;
  logic [31:0] dat_i, dat_o, q[$];
  logic [2:0]  raw_out_i, out_o, d, r;
  int          mismatches = 0, comparisons = 0, seed = 95152, k, m, nn;
  sdol_top #(.TICK_CYCLES(T)) sdol_top_i (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .freq_zero_i, .above_set_i, .remote_dly_i, .release_i,
    .raw_out_i, .out_o, .delay_active_o, .standstill_o, .irq_o);
  sdol_partner sdol_partner_i (.clk_i, .press_i(press), .release_o(release_i));
  initial forever #25 clk_i = ~clk_i;
  task automatic cmp(input string w, input logic [31:0] e, s);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", w, e, s);
    end
  endtask
  always @(negedge clk_i)
    if (ack_o && !we_i) cmp("dat_o", q.pop_front(), dat_o);
    else if (look) begin
      look = 1'h0;
      cmp("ports", q.pop_front(), {26'h0, irq_o, standstill_o, delay_active_o, out_o});
    end
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i} <= {2'h3, w, a, v};
    do @(posedge clk_i); while (!ack_o); // a wait with no answer ends at the watchdog
    {cyc_i, stb_i} <= 2'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    q.push_back(e);
    wb(1'h0, a, 32'h0);
  endtask
  // {irq, standstill, delay, out[2:0]}
  task automatic see(input logic [5:0] e);
    q.push_back({26'h0, e});
    look = 1'h1;
    @(negedge clk_i);
    @(posedge clk_i);
  endtask
  task automatic go(input logic [3:0] md, lg, input logic [2:0] dl);
    wb(1'h1, SDOL_CFG_OFS, {20'h0, lg, 1'h0, dl, md});
  endtask
  // standstill time 0: a short zero burst is a standstill exit
  task automatic restart();
    freq_zero_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    freq_zero_i <= 1'h0;
    repeat (3) @(posedge clk_i);
  endtask
  task automatic pulse_out();
    raw_out_i <= 3'h1;
    @(posedge clk_i);
    raw_out_i <= 3'h0;
    repeat (2) @(posedge clk_i);
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    {cyc_i, stb_i, we_i, adr_i, dat_i, freq_zero_i, above_set_i, remote_dly_i} = 42'h0;
    {raw_out_i, press} = 4'h0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    rd(SDOL_CFG_OFS, SDOL_CFG_RST);
    rd(SDOL_MASK_OFS, 32'h0);
    rd(4'h2, 32'h0);
    go(SDOL_MODE_OFF, 4'h0, 3'h7);
    restart();
    repeat (8) begin
      r = 3'($random(seed));
      raw_out_i <= r;
      @(posedge clk_i);
      see({3'h0, r});
    end
    raw_out_i <= 3'h7;
    go(4'h2, 4'h0, 3'h0);
    restart();
    see(6'h0f);
    $display("done: reset and no delay");
    for (m = 1; m <= 8; m++) begin
      d = 3'($random(seed)) | 3'h1;
      go(4'(m), 4'h0, d);
      restart();
      if (m > 1) see({3'h1, ~d});
      nn = 1 << (m - 1);
      k = 0;
      while (delay_active_o && k < nn * T + 9) begin
        @(posedge clk_i);
        k++;
      end
      cmp("delay_len", 1, k >= (nn - 1) * T + int'(m == 1) && k <= nn * T);
      @(posedge clk_i);
      see(6'h07);
    end
    $display("done: timed delays");
    go(SDOL_MODE_AUTO, 4'h0, 3'h7);
    restart();
    repeat (30) @(posedge clk_i);
    see(6'h08);
    above_set_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    see(6'h07);
    above_set_i <= 1'h0;
    go(SDOL_MODE_REMOTE, 4'h0, 3'h2);
    remote_dly_i <= 1'h1;
    restart();
    see(6'h0d);
    remote_dly_i <= 1'h0;
    repeat (3) @(posedge clk_i);
    see(6'h07);
    $display("done: auto and remote");
    go(SDOL_MODE_OFF, 4'h1, 3'h0);
    wb(1'h1, SDOL_IRQ_OFS, 32'h7);
    pulse_out();
    see(6'h01);
    press <= 1'h1;
    @(posedge clk_i);
    press <= 1'h0;
    repeat (4) @(posedge clk_i);
    see(6'h00);
    rd(SDOL_IRQ_OFS, 32'h4);
    wb(1'h1, SDOL_MASK_OFS, 32'h4);
    see(6'h20);
    wb(1'h1, SDOL_IRQ_OFS, 32'h4);
    see(6'h00);
    go(SDOL_MODE_OFF, 4'h9, 3'h0);
    pulse_out();
    see(6'h01);
    freq_zero_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    see(6'h10);
    freq_zero_i <= 1'h0;
    $display("done: catch and interrupt");
    wb(1'h1, SDOL_CFG_OFS, 32'h0002_0000);
    freq_zero_i <= 1'h1;
    k = 0;
    while (!standstill_o && k < 40) begin
      @(posedge clk_i);
      k++;
    end
    cmp("still_len", 1, k >= 2 * T + 3 && k <= 3 * T + 2);
    rd(SDOL_STAT_OFS, 32'h2);
    $display("done: standstill time");
    stop_test();
  end
  initial begin
    #2_000_000;
    mismatches++;
    stop_test();
  end
endmodule // sdol_top_test
`default_nettype wire
